// [hw/keypad_scan_consts.svh]
// Purpose: offsets, field positions, reset values and timing counts of the keypad scan configuration
// Assumes: byte offsets of the register map are used as indices; byte address is four times the index
// Notes:   definitions only
`ifndef KEYPAD_SCAN_CONSTS_SVH
`define KEYPAD_SCAN_CONSTS_SVH

`define ROW_TIMING_IDX        8'h61
`define ROW_ENABLE_IDX        8'h62
`define SCAN_CTRL_HI_IDX      8'h63
`define SCAN_CTRL_LO_IDX      8'h64
`define IRQ_STATUS_IDX        8'h70
`define IRQ_ENABLE_IDX        8'h71
`define IRQ_CLEAR_IDX         8'h72
`define SCAN_STATUS_IDX       8'h73

`define PW_SEL_MSB            7
`define PW_SEL_LSB            6
`define WAKE_EN_BIT           5
`define SCAN_COUNT_MSB        7
`define SCAN_COUNT_LSB        4
`define DEDICATED_MSB         3
`define SCAN_START_BIT        0
`define DEBOUNCE_MSB          7
`define DEBOUNCE_LSB          1

`define ROW_TIMING_RESET      8'hc0
`define ROW_ENABLE_RESET      8'h00
`define SCAN_CTRL_HI_RESET    8'h00
`define SCAN_CTRL_LO_RESET    8'h00
`define ROW_TIMING_WMASK      8'he0

`define PW_CODE_1X            2'h0
`define PW_CODE_16X           2'h1
`define PW_CODE_64X           2'h2
`define PW_CODE_128X          2'h3
`define PW_CYCLES_1X          8'd1
`define PW_CYCLES_16X         8'd16
`define PW_CYCLES_64X         8'd64
`define PW_CYCLES_128X        8'd128

`define CLK_HZ                25000000
`define DEBOUNCE_STEP_US      1000
`define DEBOUNCE_STEP_CYCLES  ((`CLK_HZ / 1000000) * `DEBOUNCE_STEP_US)

`define IRQ_ROW_DONE_BIT      0
`define IRQ_CYCLE_DONE_BIT    1
`define IRQ_WAKE_BIT          2
`define IRQ_WIDTH             3

`endif

// [hw/keypad_scan_pkg.sv]
// Purpose: shared types of the keypad scan configuration block
// Assumes: none
// Notes:   constants live in keypad_scan_consts.svh
package keypad_scan_pkg;

  typedef enum logic [2:0]
  {
    SCAN_IDLE  = 3'b001,
    SCAN_PULSE = 3'b010,
    SCAN_NEXT  = 3'b100
  } scan_state_type;

  typedef struct packed
  {
    logic [1:0] pulse_width_sel;
    logic       hibernate_wake_enable;
    logic [7:0] row_enable;
    logic [3:0] scan_count;
    logic [3:0] dedicated_column_select;
    logic [6:0] debounce_time;
    logic       scan_start;
  } scan_cfg_type;

  typedef struct packed
  {
    logic       scanning;
    logic [2:0] row_index;
    logic [3:0] cycles_done;
    logic       confirm;
  } scan_stat_type;

endpackage

// [hw/row_pulse_timer.sv]
// Purpose: measures the width of one row pulse
// Assumes: sleep_tick is a one-cycle pulse per period of the 32 kHz clock
// Notes:   in sleep the pulse lasts from start to the next sleep tick
`timescale 1ns/1ps
`include "keypad_scan_consts.svh"
module row_pulse_timer
  import keypad_scan_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       sleep_mode,
  input  wire logic       sleep_tick,
  input  wire logic [1:0] pulse_width_sel,
  output logic            done
);

  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic       active_reg;
  logic       active_next;
  logic [7:0] width_cycles;
  logic       normal_end;
  logic       sleep_end;

  // (R1) width code decode
  assign width_cycles = (pulse_width_sel == `PW_CODE_1X)  ? `PW_CYCLES_1X  :
                        (pulse_width_sel == `PW_CODE_16X) ? `PW_CYCLES_16X :
                        (pulse_width_sel == `PW_CODE_64X) ? `PW_CYCLES_64X : `PW_CYCLES_128X;

  assign normal_end  = active_reg && !sleep_mode && (count_reg + 8'd1 >= width_cycles);
  // (R2) sleep uses one 32 kHz period
  assign sleep_end   = active_reg && sleep_mode && sleep_tick;
  assign done        = normal_end || sleep_end;
  assign active_next = start ? 1'b1 : (done ? 1'b0 : active_reg);
  assign count_next  = (start || !active_reg) ? 8'd0 : count_reg + 8'd1;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_reg  <= 8'h00;
      active_reg <= 1'b0;
    end
    else
    begin
      count_reg  <= count_next;
      active_reg <= active_next;
    end
  end

endmodule

// [hw/keypad_scan_config.sv]
// Purpose: register file and row scan sequencer of a keypad matrix scanner, AHB-Lite slave
// Assumes: single word transfers; zero wait states; sleep and hibernate levels come from power control
// Notes:   row pins are open-drain style, low while driven, released and pulled up otherwise
// Contract
// (R1) Width code 00/01/10/11 holds a row 1/16/64/128 clocks; default 11.
// (R2) In sleep each row pulse lasts one 32 kHz period, ignoring the code.
// (R3) Each row enable bit includes its row in scanning; all cleared at reset.
// (R4) Scan count nibble sets cycles elapsed before key data is confirmed.
// (R5) Low four control bits turn columns 0-3 into dedicated keys; reset clear.
// (R6) Wake enable bit 5 lets a key press wake from hibernate; reset clear.
// (R7) Enabled rows are driven low one at a time; others released.
// (R8) Start bit begins scanning when one and stops it when zero.
// (R9) Bits 7:1 hold debounce time before a press is accepted.
`timescale 1ns/1ps
`include "keypad_scan_consts.svh"
module keypad_scan_config
  import keypad_scan_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        sleep_mode,
  input  wire logic        sleep_tick,
  input  wire logic        hibernate,
  input  wire logic        key_sense,
  output logic [7:0]       row_out,
  output logic [7:0]       row_oe,
  output logic [3:0]       dedicated_column_select,
  output logic [6:0]       debounce_time,
  output logic             confirm_key,
  output logic             wake_request,
  output logic             irq
);

  logic [7:0]          row_timing_reg;
  logic [7:0]          row_enable_reg;
  logic [7:0]          ctrl_hi_reg;
  logic [7:0]          ctrl_lo_reg;
  logic [`IRQ_WIDTH-1:0] irq_status_reg;
  logic [`IRQ_WIDTH-1:0] irq_enable_reg;
  logic                wr_pend_reg;
  logic [7:0]          wr_idx_reg;
  logic [31:0]         hrdata_reg;
  scan_cfg_type        cfg;
  scan_stat_type       stat;
  scan_state_type      state_reg;
  scan_state_type      state_next;
  logic [2:0]          row_reg;
  logic [2:0]          row_next;
  logic [2:0]          first_row;
  logic [3:0]          cycle_reg;
  logic [3:0]          cycle_next;
  logic                confirm_reg;
  logic                wake_reg;
  logic                pulse_start;
  logic                pulse_done;
  logic                addr_phase;
  logic [7:0]          addr_idx;
  logic                rd_take;
  logic                wr_hit;
  logic [31:0]         rd_value;
  logic                last_row;
  logic                cycle_end;
  logic                row_done_evt;
  logic                wake_evt;
  logic [`IRQ_WIDTH-1:0] irq_events;
  logic [`IRQ_WIDTH-1:0] irq_clear;
  logic [7:0]          wdata_byte;

  function automatic logic [2:0] next_enabled_row(input logic [7:0] enables, input logic [2:0] from);
    logic [2:0] idx;
    logic [2:0] found;
    logic       hit;
    found = from;
    hit   = 1'b0;
    for (int i = 1; i <= 8; i++)
    begin
      idx = 3'(from + 3'(i));
      if (!hit && enables[idx])
      begin
        found = idx;
        hit   = 1'b1;
      end
    end
    return found;
  endfunction

  // Bus decode; one-word registers at four times the index
  assign addr_phase = hsel && hready && htrans[1];
  assign addr_idx   = haddr[9:2];
  assign rd_take    = addr_phase && !hwrite;
  assign wr_hit     = wr_pend_reg;
  assign wdata_byte = hwdata[7:0];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_reg;

  assign cfg.pulse_width_sel         = row_timing_reg[`PW_SEL_MSB:`PW_SEL_LSB];
  assign cfg.hibernate_wake_enable   = row_timing_reg[`WAKE_EN_BIT];
  assign cfg.row_enable              = row_enable_reg;
  assign cfg.scan_count              = ctrl_hi_reg[`SCAN_COUNT_MSB:`SCAN_COUNT_LSB];
  assign cfg.dedicated_column_select = ctrl_hi_reg[`DEDICATED_MSB:0];
  assign cfg.debounce_time           = ctrl_lo_reg[`DEBOUNCE_MSB:`DEBOUNCE_LSB];
  assign cfg.scan_start              = ctrl_lo_reg[`SCAN_START_BIT];

  assign stat.scanning    = (state_reg != SCAN_IDLE);
  assign stat.row_index   = row_reg;
  assign stat.cycles_done = cycle_reg;
  assign stat.confirm     = confirm_reg;

  assign rd_value = (addr_idx == `ROW_TIMING_IDX)   ? {24'h000000, row_timing_reg} :
                    (addr_idx == `ROW_ENABLE_IDX)   ? {24'h000000, row_enable_reg} :
                    (addr_idx == `SCAN_CTRL_HI_IDX) ? {24'h000000, ctrl_hi_reg} :
                    (addr_idx == `SCAN_CTRL_LO_IDX) ? {24'h000000, ctrl_lo_reg} :
                    (addr_idx == `IRQ_STATUS_IDX)   ? {29'h00000000, irq_status_reg} :
                    (addr_idx == `IRQ_ENABLE_IDX)   ? {29'h00000000, irq_enable_reg} :
                    (addr_idx == `SCAN_STATUS_IDX)  ? {23'h000000, stat} : 32'h00000000;

  // (R5) dedicated columns handed to the column logic
  assign dedicated_column_select = cfg.dedicated_column_select;
  // (R9) debounce time handed to the debounce stage
  assign debounce_time = cfg.debounce_time;
  assign confirm_key   = confirm_reg;
  assign wake_request  = wake_reg;

  // (R7) one enabled row low, all others released
  assign row_out = 8'h00;
  assign row_oe  = (state_reg == SCAN_PULSE) ? (8'h01 << row_reg) : 8'h00;

  // (R3) rows with a clear enable are skipped
  assign row_next  = next_enabled_row(cfg.row_enable, row_reg);
  // Searching on from row 7 wraps to row 0, so idle loads the lowest enabled row first
  assign first_row = next_enabled_row(cfg.row_enable, 3'h7);
  assign last_row  = (row_next <= row_reg);
  assign cycle_end = (state_reg == SCAN_NEXT) && last_row;
  assign pulse_start = ((state_reg == SCAN_IDLE) && cfg.scan_start && (cfg.row_enable != 8'h00)) ||
                       ((state_reg == SCAN_NEXT) && cfg.scan_start && (cfg.row_enable != 8'h00));

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SCAN_IDLE:
      begin
        // (R8) start bit launches scanning
        if (pulse_start)
          state_next = SCAN_PULSE;
      end
      SCAN_PULSE:
      begin
        if (!cfg.scan_start)
          state_next = SCAN_IDLE;
        else if (pulse_done)
          state_next = SCAN_NEXT;
      end
      SCAN_NEXT:
      begin
        // (R8) clearing the start bit stops scanning
        state_next = pulse_start ? SCAN_PULSE : SCAN_IDLE;
      end
    endcase
  end

  // (R4) count whole cycles up to the programmed figure
  assign cycle_next = (state_reg == SCAN_IDLE) ? 4'h0 :
                      (cycle_end && (cycle_reg >= cfg.scan_count)) ? 4'h0 :
                      cycle_end ? 4'(cycle_reg + 4'h1) : cycle_reg;

  assign row_done_evt = (state_reg == SCAN_PULSE) && pulse_done;
  // (R6) wake only while enabled
  assign wake_evt   = hibernate && key_sense && cfg.hibernate_wake_enable;
  assign irq_events = {wake_evt, confirm_reg, row_done_evt};
  assign irq_clear  = (wr_hit && (wr_idx_reg == `IRQ_CLEAR_IDX)) ? wdata_byte[`IRQ_WIDTH-1:0] : '0;
  assign irq        = |(irq_status_reg & irq_enable_reg);

  row_pulse_timer u_timer
  (
    .clk             (clk),
    .rst             (rst),
    .start           (pulse_start),
    .sleep_mode      (sleep_mode),
    .sleep_tick      (sleep_tick),
    .pulse_width_sel (cfg.pulse_width_sel),
    .done            (pulse_done)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      hrdata_reg  <= 32'h00000000;
    end
    else
    begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_idx_reg  <= addr_idx;
      if (rd_take)
        hrdata_reg <= rd_value;
    end
  end

  // Register writes land in the data phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // (R1) default width code 11; (R6) wake clear
      row_timing_reg <= `ROW_TIMING_RESET;
      // (R3) all rows off
      row_enable_reg <= `ROW_ENABLE_RESET;
      // (R5) dedicated keys clear
      ctrl_hi_reg    <= `SCAN_CTRL_HI_RESET;
      ctrl_lo_reg    <= `SCAN_CTRL_LO_RESET;
      irq_enable_reg <= '0;
    end
    else if (wr_hit)
    begin
      if (wr_idx_reg == `ROW_TIMING_IDX)
        row_timing_reg <= wdata_byte & `ROW_TIMING_WMASK;
      if (wr_idx_reg == `ROW_ENABLE_IDX)
        row_enable_reg <= wdata_byte;
      if (wr_idx_reg == `SCAN_CTRL_HI_IDX)
        ctrl_hi_reg <= wdata_byte;
      if (wr_idx_reg == `SCAN_CTRL_LO_IDX)
        ctrl_lo_reg <= wdata_byte;
      if (wr_idx_reg == `IRQ_ENABLE_IDX)
        irq_enable_reg <= wdata_byte[`IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg      <= SCAN_IDLE;
      row_reg        <= 3'h0;
      cycle_reg      <= 4'h0;
      confirm_reg    <= 1'b0;
      wake_reg       <= 1'b0;
      irq_status_reg <= '0;
    end
    else
    begin
      state_reg      <= state_next;
      row_reg        <= (state_reg == SCAN_IDLE) ? first_row :
                        (state_reg == SCAN_NEXT) ? row_next : row_reg;
      cycle_reg      <= cycle_next;
      // (R4) confirm pulse after the programmed cycle count
      confirm_reg    <= cycle_end && (cycle_reg >= cfg.scan_count);
      wake_reg       <= wake_evt;
      // Set beats clear when both land together
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
    end
  end

endmodule

// [verif/key_matrix.sv]
// Purpose: key switch matrix on the row and column pins
// Assumes: one key is closed at a time
// Notes:   a released row is pulled up, so a closed key on it reads idle
`timescale 1ns/1ps
module key_matrix
(
  input  wire logic [7:0] row_oe,
  input  wire logic [7:0] row_out,
  input  wire logic       press,
  input  wire logic [2:0] press_row,
  output logic            key_sense
);
  logic [7:0] row_level;
  assign row_level = ~row_oe | row_out;
  assign key_sense = press && !row_level[press_row];
endmodule

// [verif/keypad_scan_config_props.sv]
// Purpose: concurrent checks on the keypad scan configuration ports
// Assumes: width and enable registers are rewritten only while scanning is stopped
// Notes:   register shadows are rebuilt from the bus traffic
`timescale 1ns/1ps
`include "keypad_scan_consts.svh"
module keypad_scan_config_props
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        sleep_mode,
  input wire logic        sleep_tick,
  input wire logic        hibernate,
  input wire logic        key_sense,
  input wire logic [7:0]  row_out,
  input wire logic [7:0]  row_oe,
  input wire logic [3:0]  dedicated_column_select,
  input wire logic [6:0]  debounce_time,
  input wire logic        confirm_key,
  input wire logic        wake_request
);
  logic [7:0] idx_reg;
  logic [7:0] en_reg;
  logic [7:0] on_cnt_reg;
  logic [7:0] pw_cycles;
  logic [1:0] pw_reg;
  logic [3:0] ded_reg;
  logic [6:0] db_reg;
  logic       wr_reg;
  logic       wake_reg;
  logic       start_reg;
  assign pw_cycles = (pw_reg == 2'h0) ? 8'h01 : (pw_reg == 2'h1) ? 8'h10 : (pw_reg == 2'h2) ? 8'h40 : 8'h80;
  always_ff @(posedge clk)
  begin
    wr_reg     <= !rst && hsel && hready && htrans[1] && hwrite;
    idx_reg    <= haddr[9:2];
    on_cnt_reg <= (|row_oe) ? on_cnt_reg + 8'h01 : 8'h00;
    if (rst)
      {pw_reg, wake_reg, en_reg, ded_reg, db_reg, start_reg} <= {2'h3, 21'h0};
    else if (wr_reg && idx_reg == `ROW_TIMING_IDX)
      {pw_reg, wake_reg} <= hwdata[7:5];
    else if (wr_reg && idx_reg == `ROW_ENABLE_IDX)
      en_reg <= hwdata[7:0];
    else if (wr_reg && idx_reg == `SCAN_CTRL_HI_IDX)
      ded_reg <= hwdata[3:0];
    else if (wr_reg && idx_reg == `SCAN_CTRL_LO_IDX)
      {db_reg, start_reg} <= hwdata[7:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_width;
    $fell(|row_oe) && start_reg && !sleep_mode |-> on_cnt_reg == pw_cycles;
  endproperty
  a_width: assert property (p_width) else $error("row pulse length off");
  property p_sleep;
    $fell(|row_oe) && start_reg && sleep_mode |-> $past(sleep_tick) || $past(sleep_tick, 2);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep pulse not ended by tick");
  property p_enabled;
    |row_oe |-> (row_oe & ~en_reg) == 8'h00;
  endproperty
  a_enabled: assert property (p_enabled) else $error("disabled row driven");
  property p_confirm;
    confirm_key |-> ($past(start_reg) || $past(start_reg, 2)) ##1 !confirm_key;
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirm outside scanning");
  property p_dedicated;
    dedicated_column_select == ded_reg;
  endproperty
  a_dedicated: assert property (p_dedicated) else $error("dedicated select differs");
  property p_wake;
    wake_request |-> $past(hibernate && key_sense && wake_reg);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
  property p_one_row;
    $onehot0(row_oe) && row_out == 8'h00;
  endproperty
  a_one_row: assert property (p_one_row) else $error("rows not driven low one at a time");
  property p_stop;
    (!start_reg) [*3] |-> row_oe == 8'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("rows driven while stopped");
  property p_debounce;
    debounce_time == db_reg;
  endproperty
  a_debounce: assert property (p_debounce) else $error("debounce field differs");
endmodule
bind keypad_scan_config keypad_scan_config_props u_props (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .sleep_mode(sleep_mode),
  .sleep_tick(sleep_tick), .hibernate(hibernate), .key_sense(key_sense), .row_out(row_out), .row_oe(row_oe),
  .dedicated_column_select(dedicated_column_select), .debounce_time(debounce_time),
  .confirm_key(confirm_key), .wake_request(wake_request));

// [verif/test_keypad_scan_config.sv]
// Purpose: self-checking bench of the keypad scan configuration block
// Assumes: a sleep tick every 10 clocks stands in for the slow clock
// Notes:   pulse widths are counted on falling edges
`timescale 1ns/1ps
`include "keypad_scan_consts.svh"
module test_keypad_scan_config;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        sleep_mode = 1'b0;
  logic        sleep_tick = 1'b0;
  logic        hibernate = 1'b0;
  logic        press = 1'b0;
  logic [2:0]  press_row = 3'h2;
  logic [31:0] rd, x, hrdata;
  logic [7:0]  en, f, row_oe, row_out;
  logic [3:0]  ded;
  logic [6:0]  db;
  logic        hready, hresp, key_sense, confirm_key, wake_request, irq, w;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          len;
  keypad_scan_config u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .sleep_mode(sleep_mode), .sleep_tick(sleep_tick), .hibernate(hibernate), .key_sense(key_sense),
    .row_out(row_out), .row_oe(row_oe), .dedicated_column_select(ded), .debounce_time(db),
    .confirm_key(confirm_key), .wake_request(wake_request), .irq(irq));
  key_matrix u_keys (.row_oe(row_oe), .row_out(row_out), .press(press), .press_row(press_row),
    .key_sense(key_sense));
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    sleep_tick <= (cyc % 10 == 9);
    if (cyc == 20000)
    begin
      err_total++;
      results();
    end
  end
  function automatic logic [31:0] pw_len(input int c);
    return (c == 0) ? 32'h1 : (c == 1) ? 32'h10 : (c == 2) ? 32'h40 : 32'h80;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Address phase held until ready, then data phase; read data taken at its closing edge
  task automatic bus(input logic wr_op, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr_op;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic meas();
    @(negedge clk);
    while (row_oe === 8'h00) @(negedge clk);
    f = row_oe;
    len = 0;
    while (row_oe === f)
    begin
      len++;
      @(negedge clk);
    end
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(96));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc("timing", `ROW_TIMING_IDX, 32'hc0);
    rdc("enables", `ROW_ENABLE_IDX, 32'h0);
    rdc("ctrl_hi", `SCAN_CTRL_HI_IDX, 32'h0);
    rdc("ctrl_lo", `SCAN_CTRL_LO_IDX, 32'h0);
    bus(1'b1, `ROW_TIMING_IDX, 32'hff);
    rdc("timing_mask", `ROW_TIMING_IDX, 32'he0);
    bus(1'b1, 8'h50, 32'hff);
    rdc("unmapped", 8'h50, 32'h0);
    chk("resp", {31'h0, hresp}, 32'h0);
    $display("test reset_map done");
    repeat (4)
    begin
      x = $urandom;
      bus(1'b1, `SCAN_CTRL_HI_IDX, {24'h0, x[7:0]});
      bus(1'b1, `SCAN_CTRL_LO_IDX, {24'h0, x[15:9], 1'b0});
      rdc("ctrl_hi", `SCAN_CTRL_HI_IDX, {24'h0, x[7:0]});
      chk("dedicated", {28'h0, ded}, {28'h0, x[3:0]});
      chk("debounce", {25'h0, db}, {25'h0, x[15:9]});
    end
    $display("test config done");
    for (int c = 0; c < 4; c++)
    begin
      en = (c == 0) ? 8'h80 : 8'($urandom) | 8'h20;
      bus(1'b1, `ROW_TIMING_IDX, {24'h0, 2'(c), 6'h0});
      bus(1'b1, `ROW_ENABLE_IDX, {24'h0, en});
      bus(1'b1, `SCAN_CTRL_LO_IDX, 32'h1);
      meas();
      chk("first_row", {24'h0, f}, {24'h0, en & (~en + 8'h01)});
      chk("pulse_len", 32'(len), pw_len(c));
      bus(1'b1, `SCAN_CTRL_LO_IDX, 32'h0);
      repeat (3) @(negedge clk);
      chk("stopped", {24'h0, row_oe}, 32'h0);
    end
    // One row of one clock plus its gap makes a two-clock scan cycle; count 2 confirms every third cycle
    bus(1'b1, `ROW_TIMING_IDX, 32'h0);
    bus(1'b1, `ROW_ENABLE_IDX, 32'h1);
    bus(1'b1, `SCAN_CTRL_HI_IDX, 32'h20);
    bus(1'b1, `SCAN_CTRL_LO_IDX, 32'h1);
    @(negedge clk);
    while (confirm_key !== 1'b1) @(negedge clk);
    len = 0;
    do
    begin
      len++;
      @(negedge clk);
    end
    while (confirm_key !== 1'b1);
    chk("confirm_gap", 32'(len), 32'd6);
    bus(1'b1, `SCAN_CTRL_LO_IDX, 32'h0);
    sleep_mode <= 1'b1;
    bus(1'b1, `ROW_TIMING_IDX, 32'hc0);
    bus(1'b1, `SCAN_CTRL_LO_IDX, 32'h1);
    meas();
    chk("sleep_len", {31'h0, len <= 11}, 32'h1);
    bus(1'b1, `SCAN_CTRL_LO_IDX, 32'h0);
    sleep_mode <= 1'b0;
    $display("test pulse done");
    bus(1'b1, `ROW_TIMING_IDX, 32'h0);
    bus(1'b1, `ROW_ENABLE_IDX, 32'h4);
    press <= 1'b1;
    hibernate <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, `SCAN_CTRL_LO_IDX, 32'h1);
      w = 1'b0;
      repeat (40)
      begin
        @(negedge clk);
        w |= wake_request;
      end
      bus(1'b1, `SCAN_CTRL_LO_IDX, 32'h0);
      chk("wake", {31'h0, w}, 32'(k));
      bus(1'b1, `ROW_TIMING_IDX, 32'h20);
    end
    press <= 1'b0;
    hibernate <= 1'b0;
    bus(1'b0, `IRQ_STATUS_IDX, 32'h0);
    chk("status", rd & 32'h5, 32'h5);
    @(negedge clk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    bus(1'b1, `IRQ_ENABLE_IDX, 32'h4);
    @(negedge clk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    bus(1'b1, `IRQ_CLEAR_IDX, 32'h4);
    @(negedge clk);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    $display("test wake_irq done");
    results();
  end
endmodule
